// file: logic/flfr_pkg.sv
package flfr_pkg;

    // Serial command opcodes seen on the command port
    localparam logic [7:0] FLFR_CMD_WR_NV_PARAMS = 8'h65;
    localparam logic [7:0] FLFR_CMD_WR_VOL_PARAMS_A = 8'hC0;
    localparam logic [7:0] FLFR_CMD_WR_VOL_PARAMS_B = 8'h63;
    localparam logic [7:0] FLFR_CMD_WR_FUNC_CFG = 8'h42;

    // Field positions of function_config
    localparam int FLFR_FN_RST_DIS_BIT = 0;
    localparam int FLFR_FN_SIDE_BIT = 1;
    localparam int FLFR_FN_PROG_PAUSE_BIT = 2;
    localparam int FLFR_FN_ERASE_PAUSE_BIT = 3;
    localparam int FLFR_FN_ROW_LOCK_LSB = 4;
    localparam int FLFR_FN_ROW_LOCK_MSB = 7;

    // Bits software may set; the two pause flags are hardware owned
    localparam logic [7:0] FLFR_FN_OTP_MASK = 8'hF3;

    // Field positions of read_parameters
    localparam int FLFR_RP_PIN_SEL_BIT = 7;
    localparam int FLFR_RP_DUMMY_MSB = 6;
    localparam int FLFR_RP_DUMMY_LSB = 3;
    localparam int FLFR_RP_WRAP_BIT = 2;
    localparam int FLFR_RP_BURST_MSB = 1;
    localparam int FLFR_RP_BURST_LSB = 0;

    // Values after reset
    localparam logic [7:0] FLFR_FN_RESET = 8'h00;
    localparam logic [7:0] FLFR_RP_VOL_RESET = 8'h00;
    localparam logic [7:0] FLFR_RP_NV_RESET = 8'h00;

    // Smallest wrap length in bytes; each burst code doubles it
    localparam logic [6:0] FLFR_BURST_MIN_BYTES = 7'h08;
    localparam logic [6:0] FLFR_WRAP_WHOLE_ARRAY = 7'h00;

    typedef enum logic [0:0] {
        FLFR_ST_LOAD,
        FLFR_ST_READY
    } flfr_state_type;

endpackage

// file: logic/flfr_pin_select.sv
`timescale 1ns/10ps
module flfr_pin_select #(
    parameter bit HAS_DEDICATED_RESET_PIN = 1'b1
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic clk_en,
    input wire logic reset_disable,
    input wire logic pin_function_select,
    input wire logic quad_lane_enable,
    input wire logic four_lane_command_mode,
    output logic dedicated_reset_en,
    output logic shared_pin_reset,
    output logic shared_pin_pause,
    output logic shared_pin_data3
);
    logic data_lane_3;
    logic reset_on_shared;

    // Quad lanes claim the shared pin whatever the select bit says
    assign data_lane_3 = quad_lane_enable | four_lane_command_mode;
    // A still-enabled dedicated pin forces pause on the shared pin
    assign reset_on_shared = !data_lane_3 && pin_function_select
        && (!HAS_DEDICATED_RESET_PIN || reset_disable);

    // Registered so the pad muxes never see a decode glitch
    always_ff @(posedge clk) begin
        if (reset) begin
            dedicated_reset_en <= HAS_DEDICATED_RESET_PIN;
            shared_pin_reset <= 1'b0;
            shared_pin_pause <= 1'b1;
            shared_pin_data3 <= 1'b0;
        end else if (clk_en) begin
            dedicated_reset_en <= HAS_DEDICATED_RESET_PIN && !reset_disable;
            shared_pin_reset <= reset_on_shared;
            shared_pin_pause <= !data_lane_3 && !reset_on_shared;
            shared_pin_data3 <= data_lane_3;
        end
    end
endmodule

// file: logic/flfr_config_regs.sv
`timescale 1ns/10ps
module flfr_config_regs
    import flfr_pkg::*;
#(
    parameter bit HAS_DEDICATED_RESET_PIN = 1'b1,
    parameter bit RESET_DISABLE_DEFAULT = 1'b0
) (
    input wire logic CLK,
    input wire logic RESET,
    input wire logic CLK_EN,
    input wire logic CMD_VALID,
    input wire logic [7:0] CMD_OPCODE,
    input wire logic [7:0] CMD_DATA,
    output logic CMD_READY,
    input wire logic PROGRAM_ACTIVE,
    input wire logic ERASE_ACTIVE,
    input wire logic SUSPEND_CMD,
    input wire logic RESUME_CMD,
    input wire logic QUAD_LANE_ENABLE,
    input wire logic FOUR_LANE_COMMAND_MODE,
    output logic [7:0] FUNCTION_CONFIG,
    output logic [7:0] READ_PARAMS_VOL,
    output logic [7:0] READ_PARAMS_NV,
    output logic PROTECT_AREA_SIDE,
    output logic [3:0] INFO_ROW_LOCK,
    output logic [3:0] DUMMY_CYCLES,
    output logic WRAP_ENABLE,
    output logic [6:0] WRAP_BYTES,
    output logic DEDICATED_RESET_EN,
    output logic SHARED_PIN_RESET,
    output logic SHARED_PIN_PAUSE,
    output logic SHARED_PIN_DATA3
);
    import flfr_pkg::*;

    flfr_state_type state_r;
    logic [7:0] func_r;
    logic [7:0] func_nxt;
    logic [7:0] vol_r;
    logic [7:0] nv_r;
    logic [6:0] wrap_bytes_r;
    logic cmd_take;
    logic wr_func;
    logic wr_nv;
    logic wr_vol;
    logic prog_pause_set;
    logic erase_pause_set;
    logic prog_resume;
    logic erase_resume;

    // Commands are held off until the power-up copy has been made
    assign CMD_READY = (state_r == FLFR_ST_READY);
    assign cmd_take = CLK_EN && CMD_VALID && CMD_READY;
    assign wr_func = cmd_take && (CMD_OPCODE == FLFR_CMD_WR_FUNC_CFG);
    assign wr_nv = cmd_take && (CMD_OPCODE == FLFR_CMD_WR_NV_PARAMS);
    assign wr_vol = cmd_take && (CMD_OPCODE == FLFR_CMD_WR_VOL_PARAMS_A
        || CMD_OPCODE == FLFR_CMD_WR_VOL_PARAMS_B);

    // Suspend and resume events; resume serves the innermost suspend first
    assign prog_pause_set = SUSPEND_CMD && PROGRAM_ACTIVE;
    assign erase_pause_set = SUSPEND_CMD && ERASE_ACTIVE;
    assign prog_resume = RESUME_CMD && func_r[FLFR_FN_PROG_PAUSE_BIT];
    assign erase_resume = RESUME_CMD && !func_r[FLFR_FN_PROG_PAUSE_BIT];

    // Power-up sequencing
    always_ff @(posedge CLK) begin
        if (RESET) begin
            state_r <= FLFR_ST_LOAD;
        end else if (CLK_EN) begin
            unique case (state_r)
                FLFR_ST_LOAD: state_r <= FLFR_ST_READY;
                FLFR_ST_READY: state_r <= FLFR_ST_READY;
            endcase
        end
    end

    // Next function value: sticky bits only ever gain ones
    always_comb begin
        func_nxt = func_r;
        if (wr_func) begin
            func_nxt = func_r | (CMD_DATA & FLFR_FN_OTP_MASK);
        end
        if (prog_resume) begin
            func_nxt[FLFR_FN_PROG_PAUSE_BIT] = 1'b0;
        end
        if (erase_resume) begin
            func_nxt[FLFR_FN_ERASE_PAUSE_BIT] = 1'b0;
        end
        // Set wins over a clear in the same cycle
        if (prog_pause_set) begin
            func_nxt[FLFR_FN_PROG_PAUSE_BIT] = 1'b1;
        end
        if (erase_pause_set) begin
            func_nxt[FLFR_FN_ERASE_PAUSE_BIT] = 1'b1;
        end
    end

    // Function register
    always_ff @(posedge CLK) begin
        if (RESET) begin
            func_r <= FLFR_FN_RESET | {7'h00, RESET_DISABLE_DEFAULT};
        end else if (CLK_EN) begin
            func_r <= func_nxt;
        end
    end

    // Non-volatile copy; its reset stands for the factory content
    always_ff @(posedge CLK) begin
        if (RESET) begin
            nv_r <= FLFR_RP_NV_RESET;
        end else if (wr_nv) begin
            nv_r <= CMD_DATA;
        end
    end

    // Volatile copy, loaded once from the non-volatile copy
    always_ff @(posedge CLK) begin
        if (RESET) begin
            vol_r <= FLFR_RP_VOL_RESET;
        end else if (CLK_EN && state_r == FLFR_ST_LOAD) begin
            vol_r <= nv_r;
        end else if (wr_vol) begin
            vol_r <= CMD_DATA;
        end
    end

    // Wrap length; zero means the read runs over the whole array
    always_ff @(posedge CLK) begin
        if (RESET) begin
            wrap_bytes_r <= FLFR_WRAP_WHOLE_ARRAY;
        end else if (CLK_EN) begin
            if (vol_r[FLFR_RP_WRAP_BIT]) begin
                wrap_bytes_r <= FLFR_BURST_MIN_BYTES
                    << vol_r[FLFR_RP_BURST_MSB:FLFR_RP_BURST_LSB];
            end else begin
                wrap_bytes_r <= FLFR_WRAP_WHOLE_ARRAY;
            end
        end
    end

    // Register views and decoded fields
    assign FUNCTION_CONFIG = func_r;
    assign READ_PARAMS_VOL = vol_r;
    assign READ_PARAMS_NV = nv_r;
    assign PROTECT_AREA_SIDE = func_r[FLFR_FN_SIDE_BIT];
    assign INFO_ROW_LOCK = func_r[FLFR_FN_ROW_LOCK_MSB:FLFR_FN_ROW_LOCK_LSB];
    assign DUMMY_CYCLES = vol_r[FLFR_RP_DUMMY_MSB:FLFR_RP_DUMMY_LSB];
    assign WRAP_ENABLE = vol_r[FLFR_RP_WRAP_BIT];
    assign WRAP_BYTES = wrap_bytes_r;

    // Shared pin role follows the volatile select bit and lane mode
    flfr_pin_select #(
        .HAS_DEDICATED_RESET_PIN(HAS_DEDICATED_RESET_PIN)
    ) u_pin_select (
        .clk(CLK),
        .reset(RESET),
        .clk_en(CLK_EN),
        .reset_disable(func_r[FLFR_FN_RST_DIS_BIT]),
        .pin_function_select(vol_r[FLFR_RP_PIN_SEL_BIT]),
        .quad_lane_enable(QUAD_LANE_ENABLE),
        .four_lane_command_mode(FOUR_LANE_COMMAND_MODE),
        .dedicated_reset_en(DEDICATED_RESET_EN),
        .shared_pin_reset(SHARED_PIN_RESET),
        .shared_pin_pause(SHARED_PIN_PAUSE),
        .shared_pin_data3(SHARED_PIN_DATA3)
    );

    default clocking @(posedge CLK); endclocking
    default disable iff (RESET);

    sequence s_func_write;
        wr_func && !SUSPEND_CMD && !RESUME_CMD;
    endsequence

    sequence s_param_write_nv;
        wr_nv ##1 1'b1;
    endsequence

    property p_rst_dis_sticky;
        func_r[FLFR_FN_RST_DIS_BIT] |=> func_r[FLFR_FN_RST_DIS_BIT];
    endproperty
    a_rst_dis_sticky: assert property (p_rst_dis_sticky) else $error("reset-disable bit cleared");

    property p_side_sticky;
        PROTECT_AREA_SIDE |=> PROTECT_AREA_SIDE [*3];
    endproperty
    a_side_sticky: assert property (p_side_sticky) else $error("protect side returned to top");

    property p_locks_sticky;
        ##1 (($past(INFO_ROW_LOCK) & ~INFO_ROW_LOCK) == 4'h0);
    endproperty
    a_locks_sticky: assert property (p_locks_sticky) else $error("row lock bit cleared");

    property p_prog_pause;
        CLK_EN && prog_pause_set |=> func_r[FLFR_FN_PROG_PAUSE_BIT];
    endproperty
    a_prog_pause: assert property (p_prog_pause) else $error("program pause flag not set");

    property p_prog_resume;
        CLK_EN && prog_resume && !prog_pause_set |=> !func_r[FLFR_FN_PROG_PAUSE_BIT];
    endproperty
    a_prog_resume: assert property (p_prog_resume) else $error("program pause flag not cleared");

    property p_erase_pause;
        CLK_EN && erase_pause_set |=> func_r[FLFR_FN_ERASE_PAUSE_BIT];
    endproperty
    a_erase_pause: assert property (p_erase_pause) else $error("erase pause flag not set");

    property p_ro_ignored;
        s_func_write |=> func_r[3:2] == $past(func_r[3:2])
            && (func_r & FLFR_FN_OTP_MASK) == ($past(func_r | CMD_DATA) & FLFR_FN_OTP_MASK);
    endproperty
    a_ro_ignored: assert property (p_ro_ignored) else $error("function write result wrong");

    property p_power_load;
        CLK_EN && state_r == FLFR_ST_LOAD |=> vol_r == $past(nv_r) && CMD_READY;
    endproperty
    a_power_load: assert property (p_power_load) else $error("volatile copy not loaded");

    property p_nv_only;
        s_param_write_nv |-> nv_r == $past(CMD_DATA) && vol_r == $past(vol_r);
    endproperty
    a_nv_only: assert property (p_nv_only) else $error("non-volatile write touched volatile");

    property p_vol_only;
        wr_vol |=> vol_r == $past(CMD_DATA) && nv_r == $past(nv_r);
    endproperty
    a_vol_only: assert property (p_vol_only) else $error("volatile write touched non-volatile");

    property p_pause_forced;
        CLK_EN && HAS_DEDICATED_RESET_PIN && !func_r[FLFR_FN_RST_DIS_BIT]
            && !QUAD_LANE_ENABLE && !FOUR_LANE_COMMAND_MODE
            |=> SHARED_PIN_PAUSE && !SHARED_PIN_RESET && DEDICATED_RESET_EN;
    endproperty
    a_pause_forced: assert property (p_pause_forced) else $error("shared pin not pause");

    property p_wrap_len;
        CLK_EN && WRAP_ENABLE |=> WRAP_BYTES == 7'(8 << $past(vol_r[1:0]));
    endproperty
    a_wrap_len: assert property (p_wrap_len) else $error("wrap length wrong");

    property p_data3;
        CLK_EN && (QUAD_LANE_ENABLE || FOUR_LANE_COMMAND_MODE)
            |=> SHARED_PIN_DATA3 && !SHARED_PIN_RESET && !SHARED_PIN_PAUSE;
    endproperty
    a_data3: assert property (p_data3) else $error("shared pin not data lane");
endmodule

// file: tb/flfr_host_model.sv
`timescale 1ns/10ps
// Serial host that issues one-byte register commands to the flash
module flfr_host_model (
    input wire logic clk,
    input wire logic cmd_ready,
    output logic cmd_valid,
    output logic [7:0] cmd_opcode,
    output logic [7:0] cmd_data,
    output logic timed_out
);
    // Idle bus at time zero
    initial begin
        cmd_valid = 1'b0;
        cmd_opcode = 8'h00;
        cmd_data = 8'h00;
        timed_out = 1'b0;
    end

    // Send one command after an optional idle gap; hold it until cmd_ready is seen, giving up after 50 more cycles
    task automatic send(input logic [7:0] op, input logic [7:0] d, input int gap);
        int n;
        n = 0;
        repeat (gap) @(negedge clk);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_opcode = op;
        cmd_data = d;
        @(posedge clk);
        while (cmd_ready !== 1'b1 && n < 50) begin
            n++;
            @(posedge clk);
        end
        // A command that never sees cmd_ready is reported, not silently dropped
        if (cmd_ready !== 1'b1) begin
            timed_out = 1'b1;
        end
        @(negedge clk);
        // Released lines show the inverse so stale values are never trusted
        cmd_valid = 1'b0;
        cmd_opcode = ~op;
        cmd_data = ~d;
    endtask
endmodule

// file: tb/flfr_config_regs_tb.sv
`timescale 1ns/10ps
module flfr_config_regs_tb;
    import flfr_pkg::*;
    logic clk = 1'b0;
    logic rst, clk_en, prog_act, erase_act, susp, resume, quad_en, four_lane, cmd_valid, cmd_ready;
    logic host_timeout;
    logic side, ded_en, sh_rst, sh_pause, sh_d3, wrap_en;
    logic [7:0] cmd_op, cmd_data, fn_cfg, rp_vol, rp_nv, fn_exp, nv_exp, d;
    logic [3:0] row_lock, dummy;
    logic [6:0] wrap_bytes;
    int fail_count, comparisons, cycles;
    int seed = 32'h1c4d_45c2;

    flfr_config_regs dut (.CLK(clk), .RESET(rst), .CLK_EN(clk_en), .CMD_VALID(cmd_valid),
        .CMD_OPCODE(cmd_op), .CMD_DATA(cmd_data), .CMD_READY(cmd_ready),
        .PROGRAM_ACTIVE(prog_act), .ERASE_ACTIVE(erase_act), .SUSPEND_CMD(susp),
        .RESUME_CMD(resume), .QUAD_LANE_ENABLE(quad_en), .FOUR_LANE_COMMAND_MODE(four_lane),
        .FUNCTION_CONFIG(fn_cfg), .READ_PARAMS_VOL(rp_vol), .READ_PARAMS_NV(rp_nv),
        .PROTECT_AREA_SIDE(side), .INFO_ROW_LOCK(row_lock), .DUMMY_CYCLES(dummy),
        .WRAP_ENABLE(wrap_en), .WRAP_BYTES(wrap_bytes), .DEDICATED_RESET_EN(ded_en),
        .SHARED_PIN_RESET(sh_rst), .SHARED_PIN_PAUSE(sh_pause), .SHARED_PIN_DATA3(sh_d3));

    flfr_host_model host (.clk(clk), .cmd_ready(cmd_ready), .cmd_valid(cmd_valid),
        .cmd_opcode(cmd_op), .cmd_data(cmd_data), .timed_out(host_timeout));

    // 25 MHz clock
    always #20 clk = ~clk;

    // Hang guard; the whole run needs well under a thousand cycles
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            fail_count++;
            tally_and_finish();
        end
    end

    // Expected {dedicated enable, shared reset, shared pause, shared lane 3}
    function automatic logic [3:0] pins_exp(logic dis, logic sel, logic q, logic qp);
        if (q | qp) return {~dis, 3'b001};
        if (!dis) return 4'b1010;
        return {1'b0, sel, ~sel, 1'b0};
    endfunction

    // Wrap length: zero means the whole array
    function automatic logic [6:0] wrap_exp(logic [7:0] p);
        return p[2] ? (7'h08 << p[1:0]) : 7'h00;
    endfunction

    task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic do_reset();
        rst = 1'b1;
        repeat (16) @(negedge clk);
        check("cmd_ready", 8'h00, {7'h0, cmd_ready});
        rst = 1'b0;
        repeat (2) @(negedge clk);
        check("cmd_ready", 8'h01, {7'h0, cmd_ready});
    endtask

    task automatic tally_and_finish();
        $display("fail_count=%0d comparisons=%0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Main sequence
    initial begin
        {clk_en, prog_act, erase_act, susp, resume, quad_en, four_lane} = 7'h40;
        {fail_count, comparisons, cycles} = '0;
        do_reset();
        check("function_config", 8'h00, fn_cfg);
        check("read_params_vol", 8'h00, rp_vol);
        check("pins", 8'h0A, {4'h0, ded_en, sh_rst, sh_pause, sh_d3});
        nv_exp = 8'($random(seed));
        host.send(FLFR_CMD_WR_NV_PARAMS, nv_exp, 1);
        check("read_params_nv", nv_exp, rp_nv);
        check("read_params_vol", 8'h00, rp_vol);
        // Every burst code with wrap off and on, both volatile opcodes
        for (int i = 0; i < 8; i++) begin
            d = 8'($random(seed));
            d[2:0] = i[2:0];
            host.send(i[0] ? FLFR_CMD_WR_VOL_PARAMS_A : FLFR_CMD_WR_VOL_PARAMS_B, d, i % 3);
            check("read_params_vol", d, rp_vol);
            check("read_params_nv", nv_exp, rp_nv);
            check("dummy_cycles", {4'h0, d[6:3]}, {4'h0, dummy});
            check("wrap_enable", {7'h0, d[2]}, {7'h0, wrap_en});
            @(negedge clk);
            check("wrap_bytes", {1'b0, wrap_exp(d)}, {1'b0, wrap_bytes});
        end
        // Pin function over all selections, before and after the reset pin is disabled
        for (int k = 0; k < 16; k++) begin
            if (k == 8) host.send(FLFR_CMD_WR_FUNC_CFG, 8'h01, 0);
            d = 8'($random(seed));
            d[7] = k[0];
            host.send(FLFR_CMD_WR_VOL_PARAMS_A, d, 0);
            quad_en = k[1];
            four_lane = k[2];
            repeat (2) @(negedge clk);
            check("pins", {4'h0, pins_exp(k >= 8, k[0], k[1], k[2])},
                {4'h0, ded_en, sh_rst, sh_pause, sh_d3});
        end
        // Sticky bits only gather ones; pause flags cannot be written
        fn_exp = 8'h01;
        host.send(FLFR_CMD_WR_FUNC_CFG, 8'h0E, 0);
        fn_exp = fn_exp | (8'h0E & FLFR_FN_OTP_MASK);
        check("function_config", fn_exp, fn_cfg);
        repeat (4) begin
            d = 8'($random(seed));
            host.send(FLFR_CMD_WR_FUNC_CFG, d, 0);
            fn_exp = fn_exp | (d & FLFR_FN_OTP_MASK);
            check("function_config", fn_exp, fn_cfg);
        end
        host.send(FLFR_CMD_WR_FUNC_CFG, 8'h00, 0);
        check("function_config", fn_exp, fn_cfg);
        check("row_lock", {4'h0, fn_exp[7:4]}, {4'h0, row_lock});
        check("protect_side", 8'h01, {7'h0, side});
        // Suspend during program, then during erase, each resumed
        for (int j = 0; j < 2; j++) begin
            prog_act = (j == 0);
            erase_act = (j == 1);
            susp = 1'b1;
            @(negedge clk);
            {susp, prog_act, erase_act} = 3'b000;
            check("function_config", fn_exp | (j ? 8'h08 : 8'h04), fn_cfg);
            resume = 1'b1;
            @(negedge clk);
            resume = 1'b0;
            check("function_config", fn_exp, fn_cfg);
        end
        // Frozen clock enable drops commands and suspends; unknown opcode ignored
        d = rp_vol;
        clk_en = 1'b0;
        prog_act = 1'b1;
        susp = 1'b1;
        host.send(FLFR_CMD_WR_VOL_PARAMS_A, ~d, 0);
        {clk_en, prog_act, susp} = 3'b100;
        host.send(8'h5A, ~d, 0);
        check("read_params_vol", d, rp_vol);
        check("read_params_nv", nv_exp, rp_nv);
        check("function_config", fn_exp, fn_cfg);
        // Second reset: volatile copy reloads from the non-volatile copy
        do_reset();
        // The non-volatile reset value stands for factory content, so both copies match it
        check("read_params_vol", FLFR_RP_NV_RESET, rp_vol);
        check("read_params_nv", FLFR_RP_NV_RESET, rp_nv);
        check("function_config", 8'h00, fn_cfg);
        check("pins", {4'h0, pins_exp(1'b0, 1'b0, quad_en, four_lane)},
            {4'h0, ded_en, sh_rst, sh_pause, sh_d3});
        check("host_timeout", 8'h00, {7'h0, host_timeout});
        tally_and_finish();
    end
endmodule
